// >>> hw/axilite_control_register_map.sv
/*
 * AXI4-Lite slave control register adapter for one compute engine.
 * assumes engine status comes from logic on the same clock, and that
 * the host follows AXI4-Lite handshakes.
 */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE_01 - offsets 0x00 to 0x18 kept for control words
// RULE_02 - start bit writable, clears on engine handshake
// RULE_03 - bit 1 reports done, read only
// RULE_04 - bit 2 reports idle, removable by option
// RULE_05 - bit 3 reports ready, cleared on read
// RULE_06 - bit 4 continue, self clears when consumed
// RULE_07 - bit 7 auto restart enable, optional
// RULE_08 - bit 9 interrupt indication, read only
// RULE_09 - 0x04 bit 0 global interrupt enable
// RULE_10 - 0x08 per source enables: done, ready
// RULE_11 - 0x0c status: clear on read, toggle on write
// RULE_12 - 0x10 write only restart counter, optional
// RULE_13 - 0x14/0x18 mailboxes, each optional
// RULE_14 - start write makes engine take arguments
// RULE_15 - completion sets flags, results readable
// RULE_16 - arguments placed in sequence after control
// RULE_17 - argument registers reset only by option
// RULE_18 - input valid companion bit, self clearing
// RULE_19 - engine stalls until valid, clears on use
// RULE_20 - output data read only, valid clears on read
// RULE_21 - ports carry data, valid, acknowledge
// RULE_22 - arrays use memory style port only
// RULE_23 - each group name gets own adapter
// RULE_24 - interrupt when global and source enabled
// RULE_25 - AXI4-Lite handshakes, reserved bits read zero
module axilite_control_register_map #(  // RULE_23
   parameter bit HAS_IDLE = 1'b1,
   parameter bit CHAINED = 1'b0,
   parameter bit AUTO_RESTART = 1'b1,
   parameter bit IN_MAILBOX = 1'b1,
   parameter bit OUT_MAILBOX = 1'b1,
   parameter bit ARG_RESET = 1'b1
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // axi4-lite write channels
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read channels
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // engine side
   // scalar arguments only, arrays take a memory port elsewhere
   input wire ctrl_regmap_pkg::engine_status_s engine_status,  // RULE_22
   output ctrl_regmap_pkg::engine_command_s engine_command,
   output logic interrupt,
   output logic [31:0] restart_count
);
   import ctrl_regmap_pkg::*;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
         input logic [31:0] new_v, input logic [3:0] strb);
      logic [31:0] m;
      m = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            m[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return m;
   endfunction : strb_merge

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic start_r, start_nxt, cont_r, cont_nxt, auto_r, auto_nxt;
   logic done_r, done_nxt, ready_r, ready_nxt, gie_r, gie_nxt;
   logic [1:0] ier_r, ier_nxt, isr_r, isr_nxt;
   logic [31:0] cnt_r, cnt_nxt, mbi_r, mbi_nxt, mbo_r, mbo_nxt;
   logic [31:0] a_r, a_nxt, b_r, b_nxt, ci_r, ci_nxt, co_r, co_nxt;
   logic bvld_r, bvld_nxt, covld_r, covld_nxt, irq_r, irq_nxt;
   logic awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt, bv_r, bv_nxt;
   logic arrdy_r, arrdy_nxt, rv_r, rv_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
   logic [7:0] awa_r, awa_nxt;
   logic [31:0] wd_r, wd_nxt;
   logic [3:0] ws_r, ws_nxt;

   logic wr_go, rd_go, rd_ok, wr_ok;
   logic [7:0] wa;
   logic [31:0] wd, ctrl_word, rd_val;
   logic [3:0] ws;

   // ----------------------------------------------------------------
   // bus handshake and decode
   // ----------------------------------------------------------------
   always_comb begin
      awrdy_nxt = awrdy_r;
      wrdy_nxt = wrdy_r;
      aw_got_nxt = aw_got_r;
      w_got_nxt = w_got_r;
      awa_nxt = awa_r;
      wd_nxt = wd_r;
      ws_nxt = ws_r;
      bv_nxt = bv_r;
      bresp_nxt = bresp_r;
      arrdy_nxt = arrdy_r;
      rv_nxt = rv_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      // address and data may come in either order
      if (s_axi_awvalid && awrdy_r) begin  // RULE_25
         aw_got_nxt = 1'b1;
         awa_nxt = s_axi_awaddr;
         awrdy_nxt = 1'b0;
      end
      if (s_axi_wvalid && wrdy_r) begin
         w_got_nxt = 1'b1;
         wd_nxt = s_axi_wdata;
         ws_nxt = s_axi_wstrb;
         wrdy_nxt = 1'b0;
      end
      if (wr_go) begin
         aw_got_nxt = 1'b0;
         w_got_nxt = 1'b0;
         bv_nxt = 1'b1;
         bresp_nxt = wr_ok ? RST_RESP_OKAY : RESP_SLVERR;
      end
      if (bv_r && s_axi_bready) begin
         bv_nxt = 1'b0;
         awrdy_nxt = 1'b1;
         wrdy_nxt = 1'b1;
      end
      if (rd_go) begin
         arrdy_nxt = 1'b0;
         rv_nxt = 1'b1;
         rdata_nxt = rd_val;
         rresp_nxt = rd_ok ? RST_RESP_OKAY : RESP_SLVERR;
      end
      if (rv_r && s_axi_rready) begin
         rv_nxt = 1'b0;
         arrdy_nxt = 1'b1;
      end
   end

   assign wr_go = aw_got_r && w_got_r && !bv_r;
   assign rd_go = s_axi_arvalid && arrdy_r;
   assign wa = awa_r;
   assign wd = wd_r;
   assign ws = ws_r;

   always_comb begin
      ctrl_word = RST_WORD;
      ctrl_word[BIT_START] = start_r;  // RULE_02
      ctrl_word[BIT_DONE] = done_r;  // RULE_03
      ctrl_word[BIT_IDLE] = HAS_IDLE & engine_status.idle_flag;  // RULE_04
      ctrl_word[BIT_READY] = ready_r;  // RULE_05
      ctrl_word[BIT_CONTINUE] = CHAINED & cont_r;  // RULE_06
      ctrl_word[BIT_AUTO_RESTART] = AUTO_RESTART & auto_r;  // RULE_07
      ctrl_word[BIT_INTERRUPT] = irq_r;  // RULE_08
   end

   // unmapped and write-only words answer with a slave error
   always_comb begin
      rd_val = RST_WORD;
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         OFF_BLOCK_CONTROL_WORD: rd_val = ctrl_word;
         OFF_GLOBAL_INTERRUPT_ENABLE: rd_val[0] = gie_r;  // RULE_09
         OFF_INTERRUPT_SOURCE_ENABLE: rd_val[1:0] = ier_r;  // RULE_10
         OFF_INTERRUPT_STATUS: rd_val[1:0] = isr_r;  // RULE_11
         OFF_INBOUND_MAILBOX: begin
            rd_val = mbi_r;  // RULE_13
            rd_ok = IN_MAILBOX;
         end
         OFF_OUTBOUND_MAILBOX: begin
            rd_val = mbo_r;
            rd_ok = OUT_MAILBOX;
         end
         OFF_ARG_A_DATA: rd_val = a_r;  // RULE_16
         OFF_ARG_B_DATA: rd_val = b_r;
         OFF_ARG_B_CTRL: rd_val[BIT_VALID] = bvld_r;  // RULE_18
         OFF_ARG_C_IN_DATA: rd_val = ci_r;
         OFF_ARG_C_OUT_DATA: rd_val = co_r;  // RULE_20
         OFF_ARG_C_OUT_CTRL: rd_val[BIT_VALID] = covld_r;
         default: rd_ok = 1'b0;
      endcase
   end

   always_comb begin
      wr_ok = 1'b1;
      unique case (wa)
         // low words kept for control, arguments start above
         OFF_BLOCK_CONTROL_WORD, OFF_GLOBAL_INTERRUPT_ENABLE,  // RULE_01
         OFF_INTERRUPT_SOURCE_ENABLE, OFF_INTERRUPT_STATUS,
         OFF_ARG_A_DATA, OFF_ARG_B_DATA, OFF_ARG_B_CTRL,
         OFF_ARG_C_IN_DATA: wr_ok = 1'b1;
         OFF_RESTART_COUNTER: wr_ok = AUTO_RESTART;  // RULE_12
         OFF_INBOUND_MAILBOX: wr_ok = IN_MAILBOX;
         OFF_OUTBOUND_MAILBOX: wr_ok = OUT_MAILBOX;
         default: wr_ok = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // register file and engine handshakes
   // ----------------------------------------------------------------
   logic rd_ctrl, rd_isr, rd_covld, w_en;
   logic [1:0] ev;
   assign rd_ctrl = rd_go && s_axi_araddr == OFF_BLOCK_CONTROL_WORD;
   assign rd_isr = rd_go && s_axi_araddr == OFF_INTERRUPT_STATUS;
   assign rd_covld = rd_go && s_axi_araddr == OFF_ARG_C_OUT_CTRL;
   assign w_en = wr_go && wr_ok;
   assign ev = {engine_status.ready_flag, engine_status.done_flag};

   always_comb begin
      start_nxt = start_r;
      cont_nxt = cont_r;
      auto_nxt = auto_r;
      done_nxt = done_r | engine_status.done_flag;  // RULE_15
      ready_nxt = ready_r;
      gie_nxt = gie_r;
      ier_nxt = ier_r;
      isr_nxt = isr_r;
      cnt_nxt = cnt_r;
      mbi_nxt = mbi_r;
      mbo_nxt = mbo_r;
      a_nxt = a_r;
      b_nxt = b_r;
      ci_nxt = ci_r;
      co_nxt = co_r;
      bvld_nxt = bvld_r;
      covld_nxt = covld_r;
      // engine ready handshake clears start unless auto restart is set
      if (engine_status.ready_flag && !auto_r) begin
         start_nxt = 1'b0;  // RULE_02
      end
      if (cont_r) begin
         cont_nxt = 1'b0;  // RULE_06
      end
      if (rd_ctrl) begin
         ready_nxt = 1'b0;  // RULE_05
         done_nxt = engine_status.done_flag;
      end
      if (engine_status.ready_flag) begin
         ready_nxt = 1'b1;  // RULE_05
      end
      if (rd_isr) begin
         isr_nxt = 2'b00;  // RULE_11
      end
      if (engine_status.arg_b_ack) begin  // RULE_21
         bvld_nxt = 1'b0;  // RULE_19
      end
      if (rd_covld) begin
         covld_nxt = 1'b0;  // RULE_20
      end
      if (w_en) begin
         unique case (wa)
            OFF_BLOCK_CONTROL_WORD: begin
               if (ws[0]) begin
                  if (wd[BIT_START]) begin
                     start_nxt = 1'b1;  // RULE_14
                  end
                  cont_nxt = CHAINED & wd[BIT_CONTINUE];
                  auto_nxt = AUTO_RESTART & wd[BIT_AUTO_RESTART];
               end
            end
            OFF_GLOBAL_INTERRUPT_ENABLE:
               if (ws[0]) begin
                  gie_nxt = wd[0];
               end
            OFF_INTERRUPT_SOURCE_ENABLE:
               if (ws[0]) begin
                  ier_nxt = wd[1:0];
               end
            OFF_INTERRUPT_STATUS:
               if (ws[0]) begin
                  isr_nxt = isr_r ^ wd[1:0];  // RULE_11
               end
            OFF_RESTART_COUNTER: cnt_nxt = strb_merge(cnt_r, wd, ws);
            OFF_INBOUND_MAILBOX: mbi_nxt = strb_merge(mbi_r, wd, ws);
            OFF_OUTBOUND_MAILBOX: mbo_nxt = strb_merge(mbo_r, wd, ws);
            OFF_ARG_A_DATA: a_nxt = strb_merge(a_r, wd, ws);
            OFF_ARG_B_DATA: b_nxt = strb_merge(b_r, wd, ws);
            OFF_ARG_B_CTRL:
               if (ws[0]) begin
                  bvld_nxt = wd[BIT_VALID];  // RULE_18
               end
            OFF_ARG_C_IN_DATA: ci_nxt = strb_merge(ci_r, wd, ws);
            default: begin
            end
         endcase
      end
      // hardware events win over clears in the same cycle
      isr_nxt = isr_nxt | (ev & ier_r);  // RULE_11
      if (engine_status.arg_c_out_vld) begin
         co_nxt = engine_status.arg_c_out;  // RULE_15
         covld_nxt = 1'b1;
      end
   end

   assign irq_nxt = gie_r && |(isr_nxt & ier_r);  // RULE_24

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         start_r <= 1'b0;
         cont_r <= 1'b0;
         auto_r <= 1'b0;
         done_r <= 1'b0;
         ready_r <= 1'b0;
         gie_r <= 1'b0;
         ier_r <= 2'b00;
         isr_r <= 2'b00;
         cnt_r <= RST_WORD;
         mbi_r <= RST_WORD;
         mbo_r <= RST_WORD;
         bvld_r <= 1'b0;
         covld_r <= 1'b0;
         irq_r <= 1'b0;
         awrdy_r <= 1'b1;
         wrdy_r <= 1'b1;
         bv_r <= 1'b0;
         arrdy_r <= 1'b1;
         rv_r <= 1'b0;
         bresp_r <= RST_RESP_OKAY;
         rresp_r <= RST_RESP_OKAY;
         rdata_r <= RST_WORD;
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awa_r <= OFF_BLOCK_CONTROL_WORD;
         wd_r <= RST_WORD;
         ws_r <= 4'h0;
      end else begin
         start_r <= start_nxt;
         cont_r <= cont_nxt;
         auto_r <= auto_nxt;
         done_r <= done_nxt;
         ready_r <= ready_nxt;
         gie_r <= gie_nxt;
         ier_r <= ier_nxt;
         isr_r <= isr_nxt;
         cnt_r <= cnt_nxt;
         mbi_r <= mbi_nxt;
         mbo_r <= mbo_nxt;
         bvld_r <= bvld_nxt;
         covld_r <= covld_nxt;
         irq_r <= irq_nxt;
         awrdy_r <= awrdy_nxt;
         wrdy_r <= wrdy_nxt;
         bv_r <= bv_nxt;
         arrdy_r <= arrdy_nxt;
         rv_r <= rv_nxt;
         bresp_r <= bresp_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         aw_got_r <= aw_got_nxt;
         w_got_r <= w_got_nxt;
         awa_r <= awa_nxt;
         wd_r <= wd_nxt;
         ws_r <= ws_nxt;
      end
   end

   // argument words carry no preset beyond an optional reset
   generate
      if (ARG_RESET) begin : g_arg_rst
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               a_r <= RST_WORD;  // RULE_17
               b_r <= RST_WORD;
               ci_r <= RST_WORD;
               co_r <= RST_WORD;
            end else begin
               a_r <= a_nxt;
               b_r <= b_nxt;
               ci_r <= ci_nxt;
               co_r <= co_nxt;
            end
         end
      end else begin : g_arg_norst
         always_ff @(posedge clk) begin
            a_r <= a_nxt;  // RULE_17
            b_r <= b_nxt;
            ci_r <= ci_nxt;
            co_r <= co_nxt;
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // ready flops already drop on capture, so no gating is needed
   assign s_axi_awready = awrdy_r;
   assign s_axi_wready = wrdy_r;
   assign s_axi_bvalid = bv_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arrdy_r;
   assign s_axi_rvalid = rv_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;
   assign interrupt = irq_r;
   assign restart_count = cnt_r;
   always_comb begin
      engine_command.start_request = start_r;  // RULE_14
      engine_command.continue_ack = cont_r;
      engine_command.arg_a = a_r;
      engine_command.arg_b = b_r;
      engine_command.arg_input_valid = bvld_r;  // RULE_19
      engine_command.arg_c_in = ci_r;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_irq_gate: assert property (@(posedge clk) disable iff (!arst_n)
      interrupt |-> $past(gie_r)) else $error("irq without enable"); // RULE_24
   a_isr_cor: assert property (@(posedge clk) disable iff (!arst_n)
      rd_isr && ev == 2'b00 |=> isr_r == 2'b00)
      else $error("status not cleared on read"); // RULE_11
   a_start_clr: assert property (@(posedge clk) disable iff (!arst_n)
      engine_status.ready_flag && !auto_r && !w_en |=> !start_r)
      else $error("start not cleared"); // RULE_02
   a_ready_cor: assert property (@(posedge clk) disable iff (!arst_n)
      rd_ctrl && !engine_status.ready_flag |=> !ready_r)
      else $error("ready not cleared on read"); // RULE_05
   a_bvld_ack: assert property (@(posedge clk) disable iff (!arst_n)
      engine_status.arg_b_ack && !w_en |=> !bvld_r)
      else $error("input valid not cleared"); // RULE_19
   a_covld_set: assert property (@(posedge clk) disable iff (!arst_n)
      engine_status.arg_c_out_vld |=> covld_r)
      else $error("output valid not set"); // RULE_20
   a_cont_sc: assert property (@(posedge clk) disable iff (!arst_n)
      cont_r |=> !cont_r) else $error("continue stuck"); // RULE_06
   a_rd_resp: assert property (@(posedge clk) disable iff (!arst_n)
      rd_go |=> s_axi_rvalid ##0 !s_axi_arready)
      else $error("read answer late"); // RULE_25
   a_done_seen: assert property (@(posedge clk) disable iff (!arst_n)
      engine_status.done_flag |=> done_r)
      else $error("done not shown"); // RULE_03
endmodule : axilite_control_register_map
`default_nettype wire

// >>> hw/ctrl_regmap_pkg.sv
/*
 * constants, field layout and carrier structs for the control register
 * adapter. assumes a 32-bit register bus with byte addressing.
 */
package ctrl_regmap_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_BLOCK_CONTROL_WORD = 8'h00;
   localparam logic [7:0] OFF_GLOBAL_INTERRUPT_ENABLE = 8'h04;
   localparam logic [7:0] OFF_INTERRUPT_SOURCE_ENABLE = 8'h08;
   localparam logic [7:0] OFF_INTERRUPT_STATUS = 8'h0c;
   localparam logic [7:0] OFF_RESTART_COUNTER = 8'h10;
   localparam logic [7:0] OFF_INBOUND_MAILBOX = 8'h14;
   localparam logic [7:0] OFF_OUTBOUND_MAILBOX = 8'h18;
   // arguments after the optional words: a (plain), b (valid), c (inout)
   localparam logic [7:0] OFF_ARG_A_DATA = 8'h20;
   localparam logic [7:0] OFF_ARG_B_DATA = 8'h28;
   localparam logic [7:0] OFF_ARG_B_CTRL = 8'h2c;
   localparam logic [7:0] OFF_ARG_C_IN_DATA = 8'h30;
   localparam logic [7:0] OFF_ARG_C_OUT_DATA = 8'h38;
   localparam logic [7:0] OFF_ARG_C_OUT_CTRL = 8'h3c;
   // ----------------------------------------------------------------
   // control word, interrupt source and valid bit positions
   // ----------------------------------------------------------------
   localparam int BIT_START = 0;
   localparam int BIT_DONE = 1;
   localparam int BIT_IDLE = 2;
   localparam int BIT_READY = 3;
   localparam int BIT_CONTINUE = 4;
   localparam int BIT_AUTO_RESTART = 7;
   localparam int BIT_INTERRUPT = 9;
   localparam int BIT_SRC_DONE = 0;
   localparam int BIT_SRC_READY = 1;
   localparam int BIT_VALID = 0;
   // ----------------------------------------------------------------
   // reset values and error response
   // ----------------------------------------------------------------
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [1:0] RST_RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ----------------------------------------------------------------
   // engine side carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic done_flag;
      logic idle_flag;
      logic ready_flag;
      logic arg_b_ack;
      logic [31:0] arg_c_out;
      logic arg_c_out_vld;
   } engine_status_s;

   typedef struct packed {
      logic start_request;
      logic continue_ack;
      logic [31:0] arg_a;
      logic [31:0] arg_b;
      logic arg_input_valid;
      logic [31:0] arg_c_in;
   } engine_command_s;
endpackage : ctrl_regmap_pkg

// >>> verification/axilite_control_register_map_test.sv
/*
 * self-checking bench for the control register adapter.
 * assumes default build options except CHAINED, and the engine model.
 */
`timescale 1ns/1ps
`default_nettype none
module axilite_control_register_map_test;
   import ctrl_regmap_pkg::*;
   logic clk, arst_n, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, interrupt;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, restart_count, rd;
   logic [1:0] bresp, rresp, rs;
   logic [3:0] wstrb;
   logic cont_seen;
   engine_status_s sts;
   engine_command_s cmd;
   int bad_count = 0;
   int num_checks = 0;
   // ----------------------------------------------------------------
   // design and engine
   // ----------------------------------------------------------------
   axilite_control_register_map #(
      .CHAINED(1'b1)
   ) u_axilite_control_register_map (
      .clk(clk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .engine_status(sts), .engine_command(cmd),
      .interrupt(interrupt), .restart_count(restart_count));
   engine_model u_engine_model (.clk(clk), .arst_n(arst_n), .cmd(cmd),
      .sts(sts));
   // continue lasts one cycle, so keep a sticky copy to judge
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cont_seen <= 1'b0;
      end else if (cmd.continue_ack) begin
         cont_seen <= 1'b1;
      end
   end
   // ----------------------------------------------------------------
   // host bus tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit ta, tw, tb;
      ta = 0; tw = 0; tb = 0;
      awaddr = a; wdata = d; awvalid = 1; wvalid = 1;
      for (int n = 0; n < 40 && !tb; n++) begin
         @(posedge clk);
         if (awvalid && awready) ta = 1;
         if (wvalid && wready) tw = 1;
         if (bvalid) tb = 1;
         rs = bresp;
         @(negedge clk);
         if (ta && awvalid) awvalid = 0;
         if (tw && wvalid) wvalid = 0;
      end
   endtask : wr
   task automatic rdw(input logic [7:0] a);
      bit ta, tr;
      ta = 0; tr = 0;
      araddr = a; arvalid = 1;
      for (int n = 0; n < 40 && !tr; n++) begin
         @(posedge clk);
         if (arvalid && arready) ta = 1;
         if (rvalid) tr = 1;
         rd = rdata;
         rs = rresp;
         @(negedge clk);
         if (ta && arvalid) arvalid = 0;
      end
   endtask : rdw
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset_values();
      rdw(8'h00); chk(rd, 32'h0000_0004);
      rdw(8'h04); chk(rd, 32'h0000_0000);
      rdw(8'h08); chk(rd, 32'h0000_0000);
      rdw(8'h0c); chk(rd, 32'h0000_0000);
   endtask : t_reset_values
   task automatic t_access();
      wr(8'h04, 32'hffff_ffff); rdw(8'h04); chk(rd, 32'h0000_0001);
      wr(8'h08, 32'hffff_ffff); rdw(8'h08); chk(rd, 32'h0000_0003);
      wr(8'h14, 32'ha5a5_1234); rdw(8'h14); chk(rd, 32'ha5a5_1234);
      wr(8'h18, 32'h5a5a_4321); rdw(8'h18); chk(rd, 32'h5a5a_4321);
      wr(8'h10, 32'h0000_0017); chk(restart_count, 32'h0000_0017);
      wr(8'h00, 32'h0000_0002); rdw(8'h00); chk(rd, 32'h0000_0004);
      rdw(8'h40);
      chk(rd, 32'h0000_0000);
      chk({30'h0, rs}, {30'h0, RESP_SLVERR});
      wr(8'h40, 32'h0000_0001);
      chk({30'h0, rs}, {30'h0, RESP_SLVERR});
      rdw(8'h10);
      chk({30'h0, rs}, {30'h0, RESP_SLVERR});
      wstrb = 4'h1;
      wr(8'h14, 32'hffff_ffff);
      wstrb = 4'hf;
      rdw(8'h14);
      chk(rd, 32'ha5a5_12ff);
   endtask : t_access
   task automatic t_operation();
      wr(8'h20, 32'h0000_1000); wr(8'h28, 32'h0000_0200);
      wr(8'h30, 32'h0000_0030); wr(8'h00, 32'h0000_0001);
      chk(cmd.start_request, 1'b1);
      chk(cmd.arg_a, 32'h0000_1000);
      // no valid yet: the engine must sit waiting
      repeat (10) @(negedge clk);
      chk({cmd.arg_input_valid, interrupt}, 2'b00);
      wr(8'h2c, 32'h0000_0001);
      for (int n = 0; n < 30 && !interrupt; n++) @(negedge clk);
      chk(interrupt, 1'b1);
      chk({cmd.start_request, cmd.arg_input_valid}, 2'b00);
      rdw(8'h00); chk(rd, 32'h0000_020e);
      rdw(8'h00); chk(rd, 32'h0000_0204);
      rdw(8'h38); chk(rd, 32'h0000_1230);
      rdw(8'h3c); chk(rd, 32'h0000_0001);
      rdw(8'h3c); chk(rd, 32'h0000_0000);
      rdw(8'h0c); chk(rd, 32'h0000_0003);
      rdw(8'h0c); chk(rd, 32'h0000_0000);
      chk(interrupt, 1'b0);
      wr(8'h0c, 32'h0000_0002); rdw(8'h0c); chk(rd, 32'h0000_0002);
      wr(8'h00, 32'h0000_0080); rdw(8'h00); chk(rd, 32'h0000_0084);
   endtask : t_operation
   task automatic t_continue();
      chk(cont_seen, 1'b0);
      wr(8'h00, 32'h0000_0010);
      chk(cont_seen, 1'b1);
      rdw(8'h00);
      chk(rd, 32'h0000_0004);
   endtask : t_continue
   // ----------------------------------------------------------------
   // run control
   // ----------------------------------------------------------------
   task automatic close_out();
      if (bad_count == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out
   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   initial begin
      // whole run is well under a thousand cycles
      repeat (5000) @(posedge clk);
      bad_count++;
      close_out();
   end
   initial begin
      // answers are always taken at once, so both ready lines stay up
      arst_n = 0; awvalid = 0; wvalid = 0; bready = 1; arvalid = 0;
      rready = 1; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000;
      wstrb = 4'hf;
      repeat (6) @(negedge clk);
      arst_n = 1;
      t_reset_values();
      t_access();
      t_operation();
      t_continue();
      close_out();
   end
endmodule : axilite_control_register_map_test
`default_nettype wire

// >>> verification/engine_model.sv
/*
 * behavioural compute engine facing the register adapter.
 * assumes the same clock and reset as the adapter.
 */
`timescale 1ns/1ps
`default_nettype none
module engine_model
   import ctrl_regmap_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // adapter side
   input wire ctrl_regmap_pkg::engine_command_s cmd,
   output ctrl_regmap_pkg::engine_status_s sts
);
   logic busy_r;
   logic [1:0] cnt_r;
   // ----------------------------------------------------------------
   // stall on valid, fixed four-cycle compute
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_r <= 1'b0;
         cnt_r <= 2'h0;
         sts <= '0;
         sts.idle_flag <= 1'b1;
      end else begin
         sts.done_flag <= 1'b0;
         sts.ready_flag <= 1'b0;
         sts.arg_b_ack <= 1'b0;
         sts.arg_c_out_vld <= 1'b0;
         // result is only good with its valid pulse
         sts.arg_c_out <= ~sts.arg_c_out;
         if (!busy_r && cmd.start_request && cmd.arg_input_valid) begin
            busy_r <= 1'b1;
            cnt_r <= 2'h3;
            sts.arg_b_ack <= 1'b1;
            sts.idle_flag <= 1'b0;
         end else if (busy_r && cnt_r == 2'h0) begin
            busy_r <= 1'b0;
            sts.done_flag <= 1'b1;
            sts.ready_flag <= 1'b1;
            sts.idle_flag <= 1'b1;
            sts.arg_c_out_vld <= 1'b1;
            sts.arg_c_out <= cmd.arg_a + cmd.arg_b + cmd.arg_c_in;
         end else if (busy_r) begin
            cnt_r <= cnt_r - 2'h1;
         end
      end
   end
endmodule : engine_model
`default_nettype wire
